// ==== pkg/ttte_consts.svh ====
// Purpose: Constants for the tape tension and tach encoder block.
// Assumes: One 25 MHz system clock, synchronous active-low reset.
// Notes on behaviour
// - The two arm phases, a quarter cycle apart, give arm direction by which one leads.
// - A separate midpoint marker input toggles as the arm crosses the centre of travel.
// - Passing the midpoint toward the head (marker rising) clears the arm position counter to zero.
// - Arm motion toward the head increments the arm position counter per decoded pulse.
// - Arm motion back toward the midpoint decrements the arm position counter per pulse.
// - The arm count is presented for the processor to read periodically.
// - The midpoint marker level is presented so the processor knows the side of centre.
// - The tach phases are compared in a flip-flop to give a forward-high direction level.
// - The direction level is presented for the processor to sample.
// - The tape position counter steps on each second tach phase edge, up or down by direction.
// - The marker is a level rising toward the head, and its rising edge clears the arm position counter.
// - First arm phase leading means movement toward the head.
// - First tach phase leading means forward tape motion.
`ifndef TTTE_CONSTS_SVH
`define TTTE_CONSTS_SVH
`define TTTE_ARM_WIDTH   16
`define TTTE_TAPE_WIDTH  24
`define TTTE_SYNC_STAGES 2
`define TTTE_RST_LEVEL   1'b0
`define TTTE_PIN_COUNT   5
`define TTTE_PIN_ARM_A   0
`define TTTE_PIN_ARM_B   1
`define TTTE_PIN_MID     2
`define TTTE_PIN_TACH_A  3
`define TTTE_PIN_TACH_B  4
`endif

// ==== pkg/ttte_pkg.sv ====
// Purpose: Types for the tape tension and tach encoder block.
// Assumes: Nothing beyond the constants header.
// Notes: Holds the step direction type shared with the decoder.
package ttte_pkg;
  typedef enum logic [1:0] {
    TTTE_STEP_NONE = 2'b00,
    TTTE_STEP_UP   = 2'b01,
    TTTE_STEP_DOWN = 2'b10
  } ttte_step_t;
endpackage : ttte_pkg

// ==== pkg/ttte_quad_if.sv ====
// Purpose: Carries a synchronised phase pair and its decoded step.
// Assumes: Same clock as the top module.
// Notes: The decoder drives step, the top reads it.
`timescale 1ns/100ps
interface ttte_quad_if;
  logic               phaseA;
  logic               phaseB;
  ttte_pkg::ttte_step_t step;
  modport decoder (input phaseA, input phaseB, output step);
  modport user    (output phaseA, output phaseB, input step);
endinterface : ttte_quad_if

// ==== rtl/ttte_quad_decoder.sv ====
// Purpose: Decodes one synchronised quadrature phase pair into up and down steps.
// Assumes: Phases already pass two synchroniser flip-flops.
// Notes: Counts on edges of phase B; A high on a rise of B means A leads.
`timescale 1ns/100ps
`include "ttte_consts.svh"
module ttte_quad_decoder (
  input wire logic mclk,
  input wire logic rst_n,
  ttte_quad_if.decoder quad
);
  logic prevB_reg;

  // ****************************************
  // Edge memory
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst_n == `TTTE_RST_LEVEL) begin
      prevB_reg <= '0;
    end else begin
      prevB_reg <= quad.phaseB;
    end
  end

  // ****************************************
  // Direction from phase order
  // ****************************************
  // phase order decode.
  always_comb begin
    quad.step = ttte_pkg::TTTE_STEP_NONE;
    if (quad.phaseB && !prevB_reg) begin
      quad.step = quad.phaseA ? ttte_pkg::TTTE_STEP_UP : ttte_pkg::TTTE_STEP_DOWN;
    end else if (!quad.phaseB && prevB_reg) begin
      quad.step = quad.phaseA ? ttte_pkg::TTTE_STEP_DOWN : ttte_pkg::TTTE_STEP_UP;
    end
  end
endmodule : ttte_quad_decoder

// ==== rtl/ttte_encoder.sv ====
// Purpose: Tension arm position count, tape direction and tape position count.
// Assumes: Sensor pins are asynchronous to mclk.
// Notes: All outputs come from flip-flops.
`timescale 1ns/100ps
`include "ttte_consts.svh"
module ttte_encoder #(
  parameter int ARM_WIDTH  = `TTTE_ARM_WIDTH,
  parameter int TAPE_WIDTH = `TTTE_TAPE_WIDTH
) (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  armPhaseA,
  input  wire logic                  armPhaseB,
  input  wire logic                  armMidMarker,
  input  wire logic                  tachPhaseA,
  input  wire logic                  tachPhaseB,
  output logic [ARM_WIDTH-1:0]       armCount,
  output logic                       armMidLevel,
  output logic                       motion_forward_level,
  output logic [TAPE_WIDTH-1:0]      tapeCount
);
  localparam int NSYNC = `TTTE_SYNC_STAGES;

  logic [`TTTE_PIN_COUNT-1:0] syncIn;
  logic [`TTTE_PIN_COUNT-1:0] syncOut;
  logic                       midPrev_reg;
  logic                       midRise;
  logic                       armUp;
  logic                       armDown;
  logic                       tachUp;
  logic                       tachDown;
  logic [ARM_WIDTH-1:0]       arm_reg;
  logic [TAPE_WIDTH-1:0]      tape_reg;
  logic                       forward_reg;

  ttte_quad_if armQ ();
  ttte_quad_if tachQ ();

  // ****************************************
  // Input synchronisers
  // ****************************************
  assign syncIn[`TTTE_PIN_ARM_A]  = armPhaseA;
  assign syncIn[`TTTE_PIN_ARM_B]  = armPhaseB;
  assign syncIn[`TTTE_PIN_MID]    = armMidMarker;
  assign syncIn[`TTTE_PIN_TACH_A] = tachPhaseA;
  assign syncIn[`TTTE_PIN_TACH_B] = tachPhaseB;

  for (genvar p = 0; p < `TTTE_PIN_COUNT; p++) begin : gSync
    logic [NSYNC-1:0] chain_reg;

    always_ff @(posedge mclk) begin
      if (rst_n == `TTTE_RST_LEVEL) begin
        chain_reg <= '0;
      end else begin
        chain_reg <= {chain_reg[NSYNC-2:0], syncIn[p]};
      end
    end

    assign syncOut[p] = chain_reg[NSYNC-1];
  end

  // ****************************************
  // Phase routing
  // ****************************************
  assign armQ.phaseA  = syncOut[`TTTE_PIN_ARM_A];
  assign armQ.phaseB  = syncOut[`TTTE_PIN_ARM_B];
  assign tachQ.phaseA = syncOut[`TTTE_PIN_TACH_A];
  assign tachQ.phaseB = syncOut[`TTTE_PIN_TACH_B];

  // ****************************************
  // Decoders
  // ****************************************
  // arm A leading counts toward head.
  ttte_quad_decoder armDec (
    .mclk (mclk),
    .rst_n(rst_n),
    .quad (armQ)
  );

  ttte_quad_decoder tachDec (
    .mclk (mclk),
    .rst_n(rst_n),
    .quad (tachQ)
  );

  // ****************************************
  // Step decode
  // ****************************************
  assign armUp    = (armQ.step == ttte_pkg::TTTE_STEP_UP);
  assign armDown  = (armQ.step == ttte_pkg::TTTE_STEP_DOWN);
  assign tachUp   = (tachQ.step == ttte_pkg::TTTE_STEP_UP);
  assign tachDown = (tachQ.step == ttte_pkg::TTTE_STEP_DOWN);

  // ****************************************
  // Midpoint marker
  // ****************************************
  // marker edge tracking.
  always_ff @(posedge mclk) begin
    if (rst_n == `TTTE_RST_LEVEL) begin
      midPrev_reg <= '0;
    end else begin
      midPrev_reg <= syncOut[`TTTE_PIN_MID];
    end
  end

  assign midRise = syncOut[`TTTE_PIN_MID] && !midPrev_reg;

  // ****************************************
  // Arm position counter
  // ****************************************
  // reset clears arm count.
  always_ff @(posedge mclk) begin
    if (rst_n == `TTTE_RST_LEVEL) begin
      arm_reg <= '0;
    end else if (midRise) begin
      arm_reg <= '0;
    end else if (armUp) begin
      arm_reg <= arm_reg + 1'b1;
    end else if (armDown) begin
      arm_reg <= arm_reg - 1'b1;
    end
  end

  // ****************************************
  // Tape direction and position
  // ****************************************
  // direction flip-flop.
  always_ff @(posedge mclk) begin
    if (rst_n == `TTTE_RST_LEVEL) begin
      forward_reg <= '0;
    end else if (tachUp) begin
      forward_reg <= 1'b1;
    end else if (tachDown) begin
      forward_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst_n == `TTTE_RST_LEVEL) begin
      tape_reg <= '0;
    end else if (tachUp) begin
      tape_reg <= tape_reg + 1'b1;
    end else if (tachDown) begin
      tape_reg <= tape_reg - 1'b1;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // arm count presented.
  assign armCount = arm_reg;
  assign armMidLevel = midPrev_reg;
  assign motion_forward_level = forward_reg;
  assign tapeCount = tape_reg;
endmodule : ttte_encoder

// ==== sim/ttte_encoder_properties.sv ====
// Purpose: Port assertions for the encoder.
// Assumes: Pins stay stable 3 clocks between changes.
// Notes: A pin change reaches the outputs on the third edge.
`timescale 1ns/100ps
module ttte_encoder_properties #(
  parameter int ARM_WIDTH  = 16,
  parameter int TAPE_WIDTH = 24
) (
  input wire logic                  mclk,
  input wire logic                  rst_n,
  input wire logic                  armPhaseA,
  input wire logic                  armPhaseB,
  input wire logic                  armMidMarker,
  input wire logic                  tachPhaseA,
  input wire logic                  tachPhaseB,
  input wire logic [ARM_WIDTH-1:0]  armCount,
  input wire logic                  armMidLevel,
  input wire logic                  motion_forward_level,
  input wire logic [TAPE_WIDTH-1:0] tapeCount
);
  // ***
  // Checks.
  // ***
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  arm_up_step_a: assert property ($rose(armPhaseB) && armPhaseA |->
    ##3 armCount == $past(armCount) + 1'b1) else $error("Arm up step missed.");
  arm_down_step_a: assert property ($rose(armPhaseB) && !armPhaseA |->
    ##3 armCount == $past(armCount) - 1'b1) else $error("Arm down step missed.");
  arm_fall_step_a: assert property ($fell(armPhaseB) |->
    ##3 armCount == ARM_WIDTH'($past(armCount) + ($past(armPhaseA, 3) ? -1 : 1)))
    else $error("Arm fall step wrong.");
  mid_clear_a: assert property ($rose(armMidMarker) |->
    ##3 armCount == '0 && armMidLevel) else $error("Marker clear missed.");
  mid_level_a: assert property ($past(rst_n, 3) |->
    armMidLevel == $past(armMidMarker, 3)) else $error("Marker level wrong.");
  tach_fwd_a: assert property ($rose(tachPhaseB) && tachPhaseA |->
    ##3 motion_forward_level && tapeCount == $past(tapeCount) + 1'b1)
    else $error("Forward step wrong.");
  tach_rev_a: assert property ($rose(tachPhaseB) && !tachPhaseA |->
    ##3 !motion_forward_level && tapeCount == $past(tapeCount) - 1'b1)
    else $error("Reverse step wrong.");
  reset_clear_a: assert property (disable iff (1'b0) !rst_n |=>
    armCount == '0 && tapeCount == '0 && !motion_forward_level && !armMidLevel)
    else $error("Reset clear wrong.");
  arm_up_c: cover property ($rose(armPhaseB) && armPhaseA);
  mid_rise_c: cover property ($rose(armMidMarker));
  tach_rev_c: cover property ($rose(tachPhaseB) && !tachPhaseA);
endmodule : ttte_encoder_properties
bind ttte_encoder ttte_encoder_properties #(.ARM_WIDTH(ARM_WIDTH), .TAPE_WIDTH(TAPE_WIDTH)) chk (
  .mclk(mclk), .rst_n(rst_n), .armPhaseA(armPhaseA), .armPhaseB(armPhaseB),
  .armMidMarker(armMidMarker), .tachPhaseA(tachPhaseA), .tachPhaseB(tachPhaseB),
  .armCount(armCount), .armMidLevel(armMidLevel),
  .motion_forward_level(motion_forward_level), .tapeCount(tapeCount));

// ==== sim/ttte_proc_model.sv ====
// Purpose: Motion processor that polls the encoder and times tach pulses.
// Assumes: Same clock as the encoder.
// Notes: The interval is in clocks between tach phase B rises.
`timescale 1ns/100ps
module ttte_proc_model #(
  parameter int ARM_WIDTH = 16
) (
  input  wire logic                 mclk,
  input  wire logic [ARM_WIDTH-1:0] armCount,
  input  wire logic                 forwardLevel,
  input  wire logic                 tachPhaseB,
  output logic      [ARM_WIDTH-1:0] armSeen,
  output logic                      forwardSeen,
  output int                        tachInterval
);
  logic prevB = 1'b0;
  int   cnt = 0;
  int   lastRise = 0;
  always_ff @(posedge mclk) begin
    prevB <= tachPhaseB;
    cnt   <= cnt + 1;
    if (cnt % 8 == 0) begin
      armSeen <= armCount;
      forwardSeen <= forwardLevel;
    end
    if (tachPhaseB && !prevB) begin
      tachInterval <= cnt - lastRise;
      lastRise     <= cnt;
    end
  end
endmodule : ttte_proc_model

// ==== sim/ttte_encoder_bench.sv ====
// Purpose: Self-checking bench for the encoder.
// Assumes: Pins move 1 ns after the clock edge.
// Notes: Each pin step is held 4 clocks.
`timescale 1ns/100ps
`define CHK(n, e, g) begin totalChecks++; if ((g) !== (e)) begin errCount++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module ttte_encoder_bench;
  logic        mclk = 1'b0;
  logic        rst_n;
  logic [4:0]  pins = 5'h00;
  logic [15:0] armCount;
  logic [15:0] armSeen;
  logic        armMidLevel;
  logic        forwardLevel;
  logic        forwardSeen;
  logic [23:0] tapeCount;
  int          tachInterval;
  int          errCount = 0;
  int          totalChecks = 0;
  always #20 mclk = ~mclk;
  ttte_encoder uut (.mclk(mclk), .rst_n(rst_n), .armPhaseA(pins[4]), .armPhaseB(pins[3]),
    .armMidMarker(pins[2]), .tachPhaseA(pins[1]), .tachPhaseB(pins[0]), .armCount(armCount),
    .armMidLevel(armMidLevel), .motion_forward_level(forwardLevel), .tapeCount(tapeCount));
  ttte_proc_model #(.ARM_WIDTH(16)) host (.mclk(mclk), .armCount(armCount),
    .forwardLevel(forwardLevel), .tachPhaseB(pins[0]), .armSeen(armSeen),
    .forwardSeen(forwardSeen), .tachInterval(tachInterval));
  // ***
  // Tasks.
  // ***
  task automatic put(input logic [4:0] v);
    pins = v;
    repeat (4) @(posedge mclk);
    #1;
  endtask : put
  task automatic quad(input bit tach, input bit up, input int n);
    logic [7:0] s;
    s = up ? 8'hb4 : 8'h78;
    for (int i = 0; i < 4 * n; i++) begin
      if (tach) put({pins[4:2], s[7 - 2 * (i % 4) -: 2]});
      else put({s[7 - 2 * (i % 4) -: 2], pins[2:0]});
    end
  endtask : quad
  task automatic test_reset(input int n);
    rst_n = 1'b0;
    repeat (n) @(posedge mclk);
    #1;
    `CHK("outputs", 42'h0, {armCount, armMidLevel, forwardLevel, tapeCount})
    rst_n = 1'b1;
    @(posedge mclk);
    #1;
    $display("test_reset done");
  endtask : test_reset
  task automatic test_arm;
    quad(1'b0, 1'b1, 3);
    `CHK("armCount", 16'h0006, armCount)
    quad(1'b0, 1'b0, 1);
    repeat (9) @(posedge mclk);
    #1;
    `CHK("armSeen", 16'h0004, armSeen)
    put(5'h04);
    `CHK("armCount", 16'h0000, armCount)
    `CHK("armMidLevel", 1'b1, armMidLevel)
    quad(1'b0, 1'b0, 1);
    put(5'h00);
    `CHK("armCount", 16'hfffe, armCount)
    `CHK("armMidLevel", 1'b0, armMidLevel)
    $display("test_arm done");
  endtask : test_arm
  task automatic test_tach;
    quad(1'b1, 1'b1, 2);
    `CHK("tapeCount", 24'h000004, tapeCount)
    `CHK("forwardLevel", 1'b1, forwardLevel)
    `CHK("tachInterval", 16, tachInterval)
    `CHK("forwardSeen", 1'b1, forwardSeen)
    quad(1'b1, 1'b0, 3);
    `CHK("tapeCount", 24'hfffffe, tapeCount)
    `CHK("forwardLevel", 1'b0, forwardLevel)
    `CHK("forwardSeen", 1'b0, forwardSeen)
    $display("test_tach done");
  endtask : test_tach
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  initial begin
    #100000;
    errCount++;
    give_verdict();
  end
  initial begin
    test_reset(8);
    test_arm();
    test_tach();
    test_reset(4);
    give_verdict();
  end
endmodule : ttte_encoder_bench
